// *** hw/lcs_regs.sv ***
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defines.svh"


// ****************************************
// bus timing
// ****************************************
// write: address and data may come in either order; the commit happens
// one edge after both halves are parked, bvalid rises with it and
// stands until bready is seen
// read: rvalid rises at the edge that takes the address and stands
// until rready is seen
// readies drop on a take and return at the same edge that accepts the
// response; a master that expects back-to-back takes will see gaps
// setpoints follow a write one edge after the commit

module lcs_regs (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // write address channel
    input  wire logic                    s_axi_awvalid,
    output var  logic                    s_axi_awready,
    input  wire lcs_pkg::lcs_addr_t      s_axi_aw,
    // write data channel
    input  wire logic                    s_axi_wvalid,
    output var  logic                    s_axi_wready,
    input  wire lcs_pkg::lcs_wdata_t     s_axi_w,
    // write response channel
    output var  logic                    s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    output var  logic [1:0]              s_axi_bresp,
    // read address channel
    input  wire logic                    s_axi_arvalid,
    output var  logic                    s_axi_arready,
    input  wire lcs_pkg::lcs_addr_t      s_axi_ar,
    // read data channel
    output var  logic                    s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output var  logic [31:0]             s_axi_rdata,
    output var  logic [1:0]              s_axi_rresp,
    // effective setpoints toward the current regulators
    output var  lcs_pkg::lcs_setpoints_t setpoints
);
    import lcs_pkg::*;

    // ****************************************
    // register storage
    // ****************************************
    // six bytes sit in flops so all three setpoints can be joined at once;
    // bits 7:2 of the high bytes are kept and read back though unused
    lcs_byte_t  regs      [0:5];   // 03h..08h, index minus 3
    lcs_byte_t  next_regs [0:5];   // next register values

    // ****************************************
    // bus handshake state
    // ****************************************
    lcs_state_t state;             // write/read phase
    lcs_state_t next_state;
    logic       aw_held;           // write address captured
    logic       next_aw_held;
    logic       w_held;            // write data captured
    logic       next_w_held;
    lcs_addr_t  aw_q;              // captured write address
    lcs_addr_t  next_aw_q;
    lcs_wdata_t w_q;               // captured write data
    lcs_wdata_t next_w_q;
    logic       next_awready;
    logic       next_wready;
    logic       next_bvalid;
    logic [1:0] next_bresp;
    logic       next_arready;
    logic       next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // ****************************************
    // address decode helpers
    // ****************************************
    // map a byte address to a storage slot; 4'hF marks a miss, so a single
    // compare covers unaligned, too-low and too-high addresses alike
    function automatic logic [3:0] slot_of(input logic [11:0] addr);
        logic [9:0] idx;   // word index of the byte address
        idx = addr[11:2];
        if (addr[1:0] != 2'h0) begin
            // unaligned: refused, never rounded onto a neighbour
            slot_of = 4'hF;
        end else if (idx >= 10'(`LCS_IDX_CH1_HIGH) && idx <= 10'(`LCS_IDX_CH3_LOW)) begin
            // inside the bank: slot is index minus three
            slot_of = 4'(idx - 10'(`LCS_IDX_CH1_HIGH));
        end else begin
            // outside the bank
            slot_of = 4'hF;
        end
    endfunction

    // a decoded slot names a stored byte
    function automatic logic slot_hit(input logic [3:0] slot);
        slot_hit = (slot != 4'hF);
    endfunction

    // response code for a decoded slot, shared by writes and reads
    function automatic logic [1:0] resp_of(input logic [3:0] slot);
        if (slot_hit(slot)) begin
            resp_of = `LCS_RESP_OKAY;
        end else begin
            // refused: a write is dropped, a read returns zero
            resp_of = `LCS_RESP_SLVERR;
        end
    endfunction

    // ch3 low byte is a plain read/write neighbour at 08h, kept here so
    // the third setpoint is complete; nothing else sits behind the bus
    // ****************************************
    // combined bus and register next state
    // ****************************************
    // one transfer at a time keeps the decode simple: a read is only
    // offered while no write half is parked, and the readies stay low
    // from a take until its response has been accepted
    always_comb begin
        logic [3:0] ws;
        logic [3:0] rs;
        ws = slot_of(aw_q.addr);
        rs = slot_of(s_axi_ar.addr);
        next_state   = state;
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_q    = aw_q;
        next_w_q     = w_q;
        next_awready = 1'b0;
        next_wready  = 1'b0;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_arready = 1'b0;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        for (int i = 0; i < 6; i++) begin
            next_regs[i] = regs[i];
        end
        case (state)
            LCS_IDLE: begin
                // address and data taken in either order
                if (!aw_held && s_axi_awvalid && s_axi_awready) begin
                    next_aw_held = 1'b1;
                    next_aw_q    = s_axi_aw;
                end
                if (!w_held && s_axi_wvalid && s_axi_wready) begin
                    next_w_held = 1'b1;
                    next_w_q    = s_axi_w;
                end
                if (aw_held && w_held) begin
                    // both halves present: commit, lane 0 only carries data
                    // high bytes stored whole
                    // low bytes stored whole
                    // lane 0 alone carries data; upper lanes are ignored since
                    // each register is one byte wide
                    if (slot_hit(ws) && w_q.strb[0]) begin
                        next_regs[ws[2:0]] = w_q.data[7:0];
                    end
                    // a refused write still gets its response, so the master never stalls
                    next_bresp   = resp_of(ws);
                    next_bvalid  = 1'b1;
                    next_aw_held = 1'b0;
                    next_w_held  = 1'b0;
                    next_state   = LCS_WRESP;
                end else if (s_axi_arvalid && s_axi_arready) begin
                    // read served when no write is half captured
                    // read returns stored byte
                    next_rdata  = slot_hit(rs) ? {24'h000000, regs[rs[2:0]]} : 32'h00000000;
                    next_rresp  = resp_of(rs);
                    next_rvalid = 1'b1;
                    next_state  = LCS_RDATA;
                end else begin
                    // keep ready up for whichever half is still missing
                    next_awready = !next_aw_held && !(s_axi_awvalid && s_axi_awready);
                    next_wready  = !next_w_held && !(s_axi_wvalid && s_axi_wready);
                    // a parked write half closes the read side; otherwise a read
                    // could slip in between the address and data of one write
                    next_arready = !next_aw_held && !next_w_held && !(s_axi_arvalid && s_axi_arready);
                end
            end
            LCS_WRESP: begin
                // hold response until master accepts
                if (s_axi_bready) begin
                    next_bvalid  = 1'b0;
                    next_state   = LCS_IDLE;
                    next_awready = 1'b1;
                    next_wready  = 1'b1;
                    next_arready = 1'b1;
                end
            end
            LCS_RDATA: begin
                // hold read data until master accepts
                if (s_axi_rready) begin
                    next_rvalid  = 1'b0;
                    next_state   = LCS_IDLE;
                    // a write half taken beside the read stays parked; its
                    // ready stays low so the same half is not taken twice
                    next_awready = !aw_held;
                    next_wready  = !w_held;
                    next_arready = !aw_held && !w_held;
                end
            end
            default: begin
                next_state = LCS_IDLE;
            end
        endcase
    end

    // ****************************************
    // registers only
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state         <= LCS_IDLE;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_q          <= '0;
            w_q           <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
            for (int i = 0; i < 6; i++) begin
                regs[i] <= `LCS_REG_RESET;
            end
        end else begin
            state         <= next_state;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_q          <= next_aw_q;
            w_q           <= next_w_q;
            // readies come straight from the next-state logic; after reset
            // release nothing is held, so the idle branch raises them at the
            // first edge and a request is taken from the second edge on
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            for (int i = 0; i < 6; i++) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // ****************************************
    // setpoint outputs
    // ****************************************
    // the regulators turn each code into led current; this side only has
    // to hand the code over unaltered and glitch-free
    // step size set by regulator
    lcs_code_join u_join_ch1 (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .high_byte (regs[0]),
        .low_byte  (regs[1]),
        .code      (setpoints.ch1)
    );
    lcs_code_join u_join_ch2 (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .high_byte (regs[2]),
        .low_byte  (regs[3]),
        .code      (setpoints.ch2)
    );
    lcs_code_join u_join_ch3 (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .high_byte (regs[4]),
        .low_byte  (regs[5]),
        .code      (setpoints.ch3)
    );
endmodule
`default_nettype wire

// *** hw/lcs_defines.svh ***
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH

// ****************************************
// register byte offsets (index) and widths
// ****************************************
`define LCS_IDX_CH1_HIGH      8'h03
`define LCS_IDX_CH1_LOW       8'h04
`define LCS_IDX_CH2_HIGH      8'h05
`define LCS_IDX_CH2_LOW       8'h06
`define LCS_IDX_CH3_HIGH      8'h07
`define LCS_IDX_CH3_LOW       8'h08
`define LCS_ADDR_W            12
`define LCS_DATA_W            32
`define LCS_REG_W             8
`define LCS_CODE_W            10
`define LCS_HIGH_LSB          0
`define LCS_HIGH_MSB          1
`define LCS_REG_RESET         8'h00
`define LCS_CODE_MAX          10'h3FF
// ****************************************
// axi response codes
// ****************************************
`define LCS_RESP_OKAY         2'h0
`define LCS_RESP_SLVERR       2'h2

`endif

// *** hw/lcs_pkg.sv ***
`default_nettype none
// ****************************************
// shared types
// ****************************************
package lcs_pkg;
    // one register byte
    typedef logic [7:0] lcs_byte_t;
    // one ten-bit current code
    typedef logic [9:0] lcs_code_t;
    // all three setpoints together
    typedef struct packed {
        lcs_code_t ch3;
        lcs_code_t ch2;
        lcs_code_t ch1;
    } lcs_setpoints_t;
    // axi write address / data payload
    typedef struct packed {
        logic [11:0] addr;
    } lcs_addr_t;
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
    } lcs_wdata_t;
    // slave bus state
    typedef enum logic [1:0] {
        LCS_IDLE  = 2'b00,
        LCS_WRESP = 2'b01,
        LCS_RDATA = 2'b10
    } lcs_state_t;
endpackage
`default_nettype wire

// *** hw/lcs_code_join.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defines.svh"

// ****************************************
// setpoint assembly, registered
// ****************************************
module lcs_code_join (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire lcs_pkg::lcs_byte_t      high_byte,
    input  wire lcs_pkg::lcs_byte_t      low_byte,
    output var  lcs_pkg::lcs_code_t      code
);
    import lcs_pkg::*;

    lcs_code_t next_code;   // joined code before the flop

    // high two bits above the low byte; no clamping, 3FF passes
    always_comb begin
        next_code = {high_byte[`LCS_HIGH_MSB:`LCS_HIGH_LSB], low_byte};
    end

    // flop keeps the output glitch-free toward the regulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code <= 10'h000;
        end else begin
            code <= next_code;
        end
    end
endmodule
`default_nettype wire

// *** verif/lcs_regs_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defines.svh"

// ****************************************
// bus and setpoint checker
// ****************************************
module lcs_regs_monitor (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire lcs_pkg::lcs_addr_t      s_axi_aw,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire lcs_pkg::lcs_wdata_t     s_axi_w,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic [1:0]              s_axi_bresp,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire lcs_pkg::lcs_addr_t      s_axi_ar,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic [1:0]              s_axi_rresp,
    input wire lcs_pkg::lcs_setpoints_t setpoints
);
    import lcs_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write halves taken at one edge
    wire w_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    wr_answer_a: assert property (w_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    rst_zero_a: assert property ($rose(aresetn) |-> setpoints == '0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("state not clear after reset");
    bad_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_ar.addr == 12'h024
        |=> s_axi_rresp == `LCS_RESP_SLVERR && s_axi_rdata == '0) else $error("unmapped read not refused");
    bad_wr_a: assert property (w_take && s_axi_aw.addr == 12'h024
        |-> ##2 s_axi_bresp == `LCS_RESP_SLVERR && $stable(setpoints)) else $error("unmapped write not refused");
    sp_quiet_a: assert property ($changed(setpoints)
        |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("setpoint moved alone");
    rdy_busy_a: assert property (s_axi_bvalid || s_axi_rvalid |-> !s_axi_awready && !s_axi_arready)
        else $error("request accepted while busy");
    c_wr: cover property (w_take ##2 s_axi_bvalid);
    c_rd: cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == `LCS_RESP_SLVERR);
endmodule

bind lcs_regs lcs_regs_monitor i_lcs_regs_monitor (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_aw(s_axi_aw), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_w(s_axi_w), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_ar(s_axi_ar), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .setpoints(setpoints));
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defines.svh"

module tb_top;
    import lcs_pkg::*;
    // ****************************************
    // bench signals
    // ****************************************
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire lcs_setpoints_t sp;
    lcs_addr_t aw = '0, ar = '0;
    lcs_wdata_t w = '0;
    lcs_byte_t er [6] = '{default: 8'h00}; // expected register bytes
    int n_mismatch = 0, comparisons = 0;
    always #2.5 aclk = ~aclk;
    lcs_regs i_lcs_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_aw(aw), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_w(w), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_ar(ar), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .setpoints(sp));
    // ****************************************
    // reporting
    // ****************************************
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: response %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_sp(input lcs_setpoints_t got, input lcs_setpoints_t exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: setpoints %h expected %h", $time, got, exp);
        end
    endtask
    // a wait that ran out ends the run
    task automatic hang();
        n_mismatch++;
        $display("wrong value at %0t: no response", $time);
        summarize();
    endtask
    // ****************************************
    // bus tasks, entered just after a rising edge
    // ****************************************
    // lag holds bready low for a few edges so the response must stand
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] ex,
                      input int lag = 0);
        int n;
        awvalid <= 1'b1;
        aw.addr <= a;
        wvalid  <= 1'b1;
        w       <= '{data: {24'hA5A5A5, d}, strb: s}; // upper lanes must be ignored
        bready  <= (lag == 0);
        for (n = 0; n < 40 && !(bvalid && bready); n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (!bready && n + 1 >= lag) bready <= 1'b1;
        end
        bready <= 1'b0;
        if (n == 40) hang();
        chk_resp(bresp, ex);
        // one idle edge, so no signal is driven twice in one step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] ex, input int lag = 0);
        int n;
        arvalid <= 1'b1;
        ar.addr <= a;
        rready  <= (lag == 0);
        for (n = 0; n < 40 && !(rvalid && rready); n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (!rready && n + 1 >= lag) rready <= 1'b1;
        end
        rready <= 1'b0;
        if (n == 40) hang();
        chk(rdata, {24'h0, ed[7:0]});
        chk_resp(rresp, ex);
        @(posedge aclk);
    endtask
    // read every byte back, then the joined setpoints
    task automatic rd_all();
        for (int i = 0; i < 6; i++) begin
            rd(12'(12 + 4 * i), {24'h0, er[i]}, `LCS_RESP_OKAY);
        end
        chk_sp(sp, {er[4][1:0], er[5], er[2][1:0], er[3], er[0][1:0], er[1]});
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_rw();
        lcs_byte_t td [2][6] = '{'{8'hFF, 8'hFF, 8'hA7, 8'h00, 8'h54, 8'h5A},
                                 '{8'hFC, 8'h00, 8'h03, 8'hFF, 8'h01, 8'h80}};
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 6; i++) begin
                wr(12'(12 + 4 * i), td[r][i], r ? 4'hF : 4'h1, `LCS_RESP_OKAY);
                er[i] = td[r][i];
            end
            rd_all();
        end
    endtask
    // unmapped, unaligned and masked writes change nothing
    task automatic t_refuse();
        wr(12'h024, 8'h33, 4'h1, `LCS_RESP_SLVERR, 3);
        wr(12'h011, 8'h33, 4'h1, `LCS_RESP_SLVERR);
        wr(12'h010, 8'h33, 4'h0, `LCS_RESP_OKAY);
        rd(12'h024, 32'h0, `LCS_RESP_SLVERR, 3);
        rd(12'h000, 32'h0, `LCS_RESP_SLVERR);
        rd_all();
    endtask
    task automatic t_rst();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        er = '{default: 8'h00};
        rd_all();
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_all();
        t_rw();
        t_refuse();
        t_rst();
        summarize();
    end
endmodule
`default_nettype wire
